//--- logic/sync_pkg.sv
// Constants and types for the link sync request control block
// Behaviour
// RQ1: Select 0 in 8b/10b uses single-ended pin
// RQ2: 64b/66b modes ignore request for initialisation
// RQ3: Request low starts code group synchronisation
// RQ4: Request high after sync starts lane alignment
// RQ5: Select 1 takes request from differential pair
// RQ6: Board grounds unused single-ended pin
// RQ7: Differential request is active low
// RQ8: Differential pair needs receiver enable set
// RQ9: Keep sync characters while request stays low
package sync_pkg;
   // ****************************************
   // Settings and timing
   // ****************************************
   localparam logic       SEL_SINGLE    = 1'b0; // Single-ended source
   localparam logic       SEL_DIFF      = 1'b1; // Differential source
   localparam int         ALIGN_LEN     = 4;    // Lane alignment cycles
   localparam logic [3:0] ALIGN_CNT_RST = 4'h0; // Counter reset value

   // Link phases
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_CGS,
      PH_ALIGN,
      PH_DATA
   } phase_e;
endpackage

//--- logic/sync_req_if.sv
// Interface carrying the conditioned sync request between modules
`timescale 1ns/1ps
interface sync_req_if;
   logic req_low;   // Request asserted (active after conditioning)
   logic req_valid; // Selected source is usable
   modport src (output req_low, output req_valid);
   modport dst (input  req_low, input  req_valid);
endinterface

//--- logic/sync_src_sel.sv
// Sync source selection and pin synchronisers
`timescale 1ns/1ps
module sync_src_sel
   import sync_pkg::*;
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // Pins and settings
   input  wire logic single_ended_sync_in_n,
   input  wire logic timestamp_diff_pair,
   input  wire logic sync_source_select,
   input  wire logic timestamp_receiver_enable,
   // Conditioned request
   sync_req_if.src   req
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [2:0] se_sh; // Single-ended sync chain
      logic [2:0] df_sh; // Differential sync chain
      logic       se_lv; // Accepted single-ended level
      logic       df_lv; // Accepted differential level
   } sel_s;

   sel_s st_r;
   sel_s st_nxt;

   // Next state: three stages, change once stages two and three agree
   always_comb begin
      st_nxt       = st_r;
      st_nxt.se_sh = {st_r.se_sh[1:0], single_ended_sync_in_n};
      st_nxt.df_sh = {st_r.df_sh[1:0], timestamp_diff_pair};
      if (st_r.se_sh[2] == st_r.se_sh[1]) begin
         st_nxt.se_lv = st_r.se_sh[2];
      end
      if (st_r.df_sh[2] == st_r.df_sh[1]) begin
         st_nxt.df_lv = st_r.df_sh[2];
      end
      if (!rst_n) begin
         st_nxt = '{se_sh: 3'h7, df_sh: 3'h7, se_lv: 1'b1, df_lv: 1'b1};
      end
   end

   // Register
   always_ff @(posedge clock) begin
      st_r <= st_nxt;
   end

   // Source choice; both sources active low
   always_comb begin
      if (sync_source_select == SEL_DIFF) begin // RQ5
         req.req_low   = ~st_r.df_lv;                // RQ7
         req.req_valid = timestamp_receiver_enable;  // RQ8
      end else begin
         req.req_low   = ~st_r.se_lv;                // RQ1
         req.req_valid = 1'b1;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   // Differential source stays unusable while its receiver is off
   a_diff_needs_en: assert property ( // RQ8
      @(posedge clock) disable iff (!rst_n)
      sync_source_select && !timestamp_receiver_enable |-> !req.req_valid)
      else $error("diff source valid without enable");
endmodule

//--- logic/jesd_sync_link_init_control.sv
// Link initialisation control driven by the sync request
`timescale 1ns/1ps
module jesd_sync_link_init_control
   import sync_pkg::*;
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // Sync pins
   input  wire logic single_ended_sync_in_n,
   input  wire logic timestamp_diff_pair,
   // Settings
   input  wire logic sync_source_select,
   input  wire logic timestamp_receiver_enable,
   input  wire logic mode_64b66b,
   // Lane control
   output logic      send_cgs,
   output logic      send_ilas,
   output logic      send_data,
   output logic      nco_sync_req
);
   // ****************************************
   // Source selection
   // ****************************************
   // Conditioned request from the selector
   sync_req_if req ();

   // Pin synchronisers and source choice
   sync_src_sel u_sel (
      .clock                     (clock),
      .rst_n                     (rst_n),
      .single_ended_sync_in_n    (single_ended_sync_in_n),
      .timestamp_diff_pair       (timestamp_diff_pair),
      .sync_source_select        (sync_source_select),
      .timestamp_receiver_enable (timestamp_receiver_enable),
      .req                       (req.src)
   );

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      phase_e     ph;    // Link phase
      logic [3:0] cnt;   // Alignment cycle count
      logic       cgs;   // Sync characters output
      logic       ilas;  // Alignment output
      logic       dat;   // Data output
      logic       nco;   // NCO sync request output
   } ctl_s;

   // Current and next state
   ctl_s st_r;
   ctl_s st_nxt;
   logic asserted;  // Usable request held low

   // Request counts only when its source is usable
   assign asserted = req.req_low && req.req_valid;

   // Next state of the link phase machine
   always_comb begin
      st_nxt     = st_r;
      st_nxt.nco = asserted; // Request still usable for NCO sync
      if (mode_64b66b) begin
         st_nxt.ph = PH_DATA; // RQ2
      end else begin
         case (st_r.ph)
            // Waiting for a request
            PH_IDLE: begin
               if (asserted) begin
                  st_nxt.ph = PH_CGS; // RQ3
               end
            end
            // Sync characters until release
            PH_CGS: begin
               if (!asserted) begin
                  st_nxt.ph  = PH_ALIGN; // RQ4
                  st_nxt.cnt = ALIGN_CNT_RST;
               end
            end
            // Alignment sequence
            PH_ALIGN: begin
               if (asserted) begin
                  st_nxt.ph = PH_CGS;
               end else if (st_r.cnt == 4'(ALIGN_LEN - 1)) begin
                  st_nxt.ph = PH_DATA;
               end else begin
                  st_nxt.cnt = st_r.cnt + 4'h1;
               end
            end
            // Data; a new request restarts sync
            PH_DATA: begin
               if (asserted) begin
                  st_nxt.ph = PH_CGS; // RQ3
               end
            end
            default: st_nxt.ph = PH_IDLE;
         endcase
      end
      // Phase outputs follow the next phase, so they leave flip-flops
      st_nxt.cgs  = (st_nxt.ph == PH_CGS); // RQ9
      st_nxt.ilas = (st_nxt.ph == PH_ALIGN);
      st_nxt.dat  = (st_nxt.ph == PH_DATA);
      // Synchronous reset overrides every other choice
      if (!rst_n) begin
         st_nxt = '{ph: PH_IDLE, cnt: ALIGN_CNT_RST, cgs: 1'b0,
                    ilas: 1'b0, dat: 1'b0, nco: 1'b0};
      end
   end

   // Register
   always_ff @(posedge clock) begin
      st_r <= st_nxt;
   end

   // Registered lane control outputs
   assign send_cgs     = st_r.cgs;
   assign send_ilas    = st_r.ilas;
   assign send_data    = st_r.dat;
   assign nco_sync_req = st_r.nco;

   // ****************************************
   // Checks
   // ****************************************
   // Usable request in 8b/10b gives sync characters next cycle
   a_cgs_on_req: assert property ( // RQ3
      @(posedge clock) disable iff (!rst_n)
      !mode_64b66b && asserted |=> send_cgs)
      else $error("request low did not give sync characters");

   // Sync characters stay while the request stays low
   a_cgs_held: assert property ( // RQ9
      @(posedge clock) disable iff (!rst_n)
      send_cgs && asserted && !mode_64b66b |=> send_cgs)
      else $error("sync characters dropped while request low");

   // Release during sync starts the alignment sequence
   a_align_on_rel: assert property ( // RQ4
      @(posedge clock) disable iff (!rst_n)
      send_cgs && !asserted && !mode_64b66b |=> send_ilas)
      else $error("release did not start alignment");

   // 64b/66b goes straight to data, no sync or alignment
   a_no_init_64: assert property ( // RQ2
      @(posedge clock) disable iff (!rst_n)
      mode_64b66b |=> send_data && !send_cgs && !send_ilas)
      else $error("64b66b mode used request for init");

   // Undisturbed alignment lasts four cycles, then data
   a_align_len: assert property ( // RQ4
      @(posedge clock) disable iff (!rst_n)
      $rose(send_ilas) && !mode_64b66b ##0 (!asserted)[*4]
      |=> send_data)
      else $error("alignment length wrong");

   // Single-ended pin low for five edges raises the request
   a_se_path: assert property ( // RQ1
      @(posedge clock) disable iff (!rst_n)
      (!sync_source_select && !single_ended_sync_in_n)[*5]
      ##1 !sync_source_select |-> req.req_low)
      else $error("single-ended path not selected");

   // Pair low for five edges raises the request, active low
   a_diff_path: assert property ( // RQ7
      @(posedge clock) disable iff (!rst_n)
      (sync_source_select && !timestamp_diff_pair)[*5]
      ##1 sync_source_select |-> req.req_low)
      else $error("differential path polarity wrong");

   // Pair held high gives no request once it is the source
   a_diff_idle: assert property ( // RQ5
      @(posedge clock) disable iff (!rst_n)
      (sync_source_select && timestamp_diff_pair)[*5]
      ##1 sync_source_select |-> !req.req_low)
      else $error("idle differential pair gave a request");

   // Pair without receiver enable never reaches the NCO request
   a_diff_gate: assert property ( // RQ8
      @(posedge clock) disable iff (!rst_n)
      sync_source_select && !timestamp_receiver_enable |=> !nco_sync_req)
      else $error("disabled pair gave an NCO request");

   // NCO request follows the usable request in every mode
   a_nco_follow: assert property ( // RQ2
      @(posedge clock) disable iff (!rst_n)
      asserted |=> nco_sync_req)
      else $error("usable request did not reach NCO output");

   // Data stands until a new usable request
   a_data_hold: assert property ( // RQ3
      @(posedge clock) disable iff (!rst_n)
      send_data && !asserted |=> send_data)
      else $error("data dropped without a request");

   // Request low during alignment falls back to sync
   a_ilas_restart: assert property ( // RQ3
      @(posedge clock) disable iff (!rst_n)
      send_ilas && asserted && !mode_64b66b |=> send_cgs)
      else $error("request in alignment did not restart sync");

   // At most one phase output at a time
   a_one_phase: assert property (
      @(posedge clock) disable iff (!rst_n)
      $onehot0({send_cgs, send_ilas, send_data}))
      else $error("more than one phase output");

   // ****************************************
   // Scenario covers
   // ****************************************
   // Sync characters start
   c_cgs: cover property (@(posedge clock) disable iff (!rst_n)
      $rose(send_cgs));

   // Alignment starts
   c_ilas: cover property (@(posedge clock) disable iff (!rst_n)
      $rose(send_ilas));

   // Data reached through the 8b/10b sequence
   c_data: cover property (@(posedge clock) disable iff (!rst_n)
      $rose(send_data) && !mode_64b66b);

   // Request used only for NCO sync in 64b/66b
   c_nco_64: cover property (@(posedge clock) disable iff (!rst_n)
      mode_64b66b && nco_sync_req);

   // New request in data restarts sync
   c_restart: cover property (@(posedge clock) disable iff (!rst_n)
      send_data && !mode_64b66b ##1 send_cgs);
endmodule

//--- dv/sync_partner.sv
// Receiver side model that drives the link sync request
`timescale 1ns/1ps
module sync_partner #(
   parameter int HOLD = 8 // Cycles held low before release
) (
   // Clock and control
   input  wire logic clock,
   input  wire logic sel,
   input  wire logic start,
   // Lane state seen
   input  wire logic send_cgs,
   // Request pins
   output logic      se_n,
   output logic      diff
);
   logic low_r; // Request held low
   int   cnt_r; // Cycles since start
   initial begin
      low_r = 1'b0;
      cnt_r = 0;
   end
   // Pull low on start, release on sync characters once HOLD cycles have passed, or after 30 cycles
   always @(posedge clock) begin
      if (start) begin
         low_r <= 1'b1;
         cnt_r <= 0;
      end else if (low_r) begin
         cnt_r <= cnt_r + 1;
         if ((send_cgs && cnt_r >= HOLD) || cnt_r >= 30) begin
            low_r <= 1'b0;
         end
      end
   end
   // Unused pin grounded, unused pair idle high
   assign se_n = sel ? 1'b0 : !low_r;
   assign diff = sel ? !low_r : 1'b1;
endmodule

//--- dv/tb_jesd_sync_link_init_control.sv
// Testbench for the link sync request control block
`timescale 1ns/1ps
module tb_jesd_sync_link_init_control;
   import sync_pkg::*;
   // ****
   // Signals
   // ****
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic sel   = 1'b0; // Source select
   logic en    = 1'b0; // Pair receiver enable
   logic mode  = 1'b0; // 64b/66b when high
   logic start = 1'b0; // Partner request trigger
   logic se_n, diff, send_cgs, send_ilas, send_data, nco_sync_req;
   int   fail_count = 0;
   int   checks = 0;
   wire  req_n = sel ? diff : se_n; // Selected request line
   // ****
   // Instances
   // ****
   jesd_sync_link_init_control i_jesd_sync_link_init_control (
      .clock(clock), .rst_n(rst_n), .single_ended_sync_in_n(se_n),
      .timestamp_diff_pair(diff), .sync_source_select(sel),
      .timestamp_receiver_enable(en), .mode_64b66b(mode),
      .send_cgs(send_cgs), .send_ilas(send_ilas),
      .send_data(send_data), .nco_sync_req(nco_sync_req));
   sync_partner i_sync_partner (.clock(clock), .sel(sel), .start(start),
      .send_cgs(send_cgs), .se_n(se_n), .diff(diff));
   // Clock, 50 ns period
   initial begin
      forever #25 clock = ~clock;
   end
   // ****
   // Helpers
   // ****
   task automatic report_and_stop;
      if (fail_count == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick;
      @(posedge clock);
      #1;
   endtask
   // Apply settings, then fire one request
   task automatic kick(input logic s, input logic e, input logic m);
      @(posedge clock);
      sel <= s;
      en <= e;
      mode <= m;
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      #1;
   endtask
   // Bounded wait on sync (0) or alignment (1)
   task automatic wait_hi(input int w);
      int n;
      n = 0;
      while (((w == 0) ? send_cgs : send_ilas) !== 1'b1) begin
         if (n == 20) begin
            fail_count++;
            report_and_stop();
         end
         tick();
         n++;
      end
   endtask
   // Full sync, alignment, data walk
   task automatic run_link;
      int n;
      wait_hi(0);
      chk(nco_sync_req, 1'b1);
      n = 0;
      while (req_n === 1'b0) begin
         if (n == 40) begin
            fail_count++;
            report_and_stop();
         end
         chk(send_cgs, 1'b1);
         tick();
         n++;
      end
      wait_hi(1);
      n = 0;
      while (send_ilas === 1'b1 && n < 20) begin
         n++;
         tick();
      end
      chk(n == ALIGN_LEN, 1'b1);
      chk(send_data, 1'b1);
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_single;
      kick(SEL_SINGLE, 1'b0, 1'b0);
      run_link();
   endtask
   task automatic t_diff;
      kick(SEL_DIFF, 1'b1, 1'b0);
      run_link();
   endtask
   task automatic t_diff_off;
      kick(SEL_DIFF, 1'b0, 1'b0);
      repeat (33) begin
         tick();
         chk(send_cgs | nco_sync_req, 1'b0);
      end
   endtask
   task automatic t_wide;
      kick(SEL_SINGLE, 1'b0, 1'b1);
      repeat (6) tick();
      chk(nco_sync_req, 1'b1);
      chk(send_cgs | send_ilas, 1'b0);
      repeat (27) tick();
   endtask
   // Mid-run reset, then a fresh link start
   task automatic t_reset;
      @(posedge clock);
      rst_n <= 1'b0;
      mode <= 1'b0;
      repeat (4) tick();
      chk(send_data | nco_sync_req, 1'b0);
      @(posedge clock);
      rst_n <= 1'b1;
      repeat (2) tick();
      chk(send_cgs | send_ilas | send_data, 1'b0);
      kick(SEL_SINGLE, 1'b0, 1'b0);
      run_link();
   endtask
   // ****
   // Main sequence
   // ****
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      t_single();
      t_diff();
      t_diff_off();
      t_wide();
      t_reset();
      report_and_stop();
   end
endmodule
